// ==== interrupt_source_vector_unit_tb.sv ====
`timescale 1ns/1ps
module interrupt_source_vector_unit_tb;
	import isvu_pkg::*;
	localparam logic [19:0] VB = 20'h3A100; // Variable table base
	localparam int SN [6] = '{8, 9, 15, 16, 15, 16};
	localparam logic [33:0] CE [5] = '{34'h800, 34'h400, 34'h200,
		34'h100, 34'h80};
	localparam logic [19:0] CA [5] = '{20'hFFFDC, 20'hFFFE0, 20'hFFFE4,
		20'hFFFF0, 20'hFFFF4};
	logic i_clk_sys, i_sys_rst, psel, penable, pwrite, pready, pslverr;
	logic rst_n, nmi_n, acc, mvalid, mrd, pc_load, hold, slow, breakpoint_instr, perr;
	logic [7:0] paddr, mdata;
	logic [31:0] pwdata, prdata, periph, rdat;
	logic [5:0] ext, vec_num;
	logic [3:0] key_n;
	logic [19:0] maddr, pc_value;
	isvu_ser_evt_t ser;
	isvu_cpu_evt_t cpu;
	int bad_count, n_compared;
	isvu_top u_isvu_top (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_prdata(prdata), .i_reset_pin_n(rst_n),
		.i_nmi_pin_n(nmi_n), .i_ext_pin(ext), .i_key_pin_n(key_n),
		.i_periph_evt(periph), .i_ser_evt(ser), .i_cpu_evt(cpu),
		.i_accept_ok(acc), .i_mem_valid(mvalid), .i_mem_data(mdata),
		.o_mem_rd(mrd), .o_mem_addr(maddr), .o_pc_load(pc_load),
		.o_pc_value(pc_value), .o_vec_num(vec_num), .o_reset_hold(hold));
	isvu_mem_model u_isvu_mem_model (.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst), .i_mem_rd(mrd), .i_mem_addr(maddr),
		.i_slow(slow), .i_brk_ff(breakpoint_instr), .o_mem_valid(mvalid),
		.o_mem_data(mdata));
	// ----
	// Checking and bus tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Setup, access, then hold until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
			if (n > 20) begin
				bad_count++;
				give_verdict();
			end
		end while (pready !== 1'b1);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rdat);
	endtask
	// Entry value as the memory model lays it out, low byte first
	function automatic logic [19:0] epc(input logic [19:0] a);
		return {4'(8'(a[7:0] + 8'h2) ^ 8'h3C), 8'(a[7:0] + 8'h1) ^ 8'h3C,
			a[7:0] ^ 8'h3C};
	endfunction
	task automatic wait_load(input logic [19:0] a, input int num);
		int n;
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
			if (n > 400) begin
				bad_count++;
				give_verdict();
			end
		end while (pc_load !== 1'b1);
		chk("pc", {12'h0, epc(a)}, {12'h0, pc_value});
		if (num >= 0) chk("vector", num, {26'h0, vec_num});
	endtask
	task automatic no_load(input int cyc);
		logic seen;
		seen = 1'b0;
		repeat (cyc) begin
			@(posedge i_clk_sys);
			if (pc_load !== 1'b0 || mrd !== 1'b0) seen = 1'b1;
		end
		chk("no fetch", 0, {31'h0, seen});
	endtask
	// One-cycle event pulse on the same-clock sources
	task automatic fire(input logic [31:0] p, input logic [5:0] s,
		input logic [33:0] c);
		@(posedge i_clk_sys);
		periph <= p;
		ser <= isvu_ser_evt_t'(s);
		cpu <= isvu_cpu_evt_t'(c);
		@(posedge i_clk_sys);
		periph <= '0;
		ser <= '0;
		cpu <= '0;
	endtask
	task automatic hit(input logic [31:0] p, input logic [5:0] s,
		input logic [33:0] c, input logic [19:0] a, input int num);
		fire(p, s, c);
		wait_load(a, num);
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end
	// ----
	// Main sequence
	// ----
	initial begin
		{i_sys_rst, rst_n, nmi_n, acc} = 4'hF;
		{psel, penable, pwrite, slow, breakpoint_instr, paddr, pwdata, periph} = '0;
		{ser, cpu, ext} = '0;
		key_n = 4'hF;
		bad_count = 0;
		n_compared = 0;
		repeat (16) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		wait_load(20'hFFFFC, -1);
		rdc("ctrl", ISVU_OFF_CTRL, 32'h0);
		rdc("unmapped", 8'h2C, 32'h0);
		chk("slverr", 1, {31'h0, perr});
		wr(ISVU_OFF_VBASE, {12'h0, VB});
		for (int k = 0; k < 4; k++) wr(ISVU_OFF_LVL0 + 8'(4 * k), 32'h11111111);
		// Unmapped write must leave every level untouched
		wr(8'h2C, 32'h77777777);
		rdc("lvl", ISVU_OFF_LVL0 + 8'h4, 32'h11111111);
		fire(32'h1 << 21, 0, 0);
		no_load(40);
		rdc("req", ISVU_OFF_REQ, 32'h1 << 21);
		wr(ISVU_OFF_CTRL, 32'h1);
		wait_load(VB + 20'd84, 21);
		rdc("req", ISVU_OFF_REQ, 32'h0);
		slow <= 1'b1;
		for (int n = 1; n < 32; n++) if (ISVU_DIRECT_MASK[n]) begin
			hit(32'h1 << n, 0, 0, VB + 20'(4 * n), n);
		end
		slow <= 1'b0;
		wr(ISVU_OFF_LVL0 + 8'h8, 32'h13111111);
		wr(ISVU_OFF_FLOOR, 32'h1);
		acc <= 1'b0;
		fire(32'h3 << 21, 0, 0);
		acc <= 1'b1;
		wait_load(VB + 20'd88, 22);
		no_load(30);
		rdc("req", ISVU_OFF_REQ, 32'h1 << 21);
		wr(ISVU_OFF_FLOOR, 32'h0);
		wait_load(VB + 20'd84, 21);
		for (int i = 0; i < 6; i++) begin
			wr(ISVU_OFF_CTRL, i < 4 ? 32'h1 : 32'h9);
			hit(0, 6'h20 >> i, 0, VB + 20'(4 * SN[i]), SN[i]);
		end
		wr(ISVU_OFF_EDGE, 32'h603);
		wr(ISVU_OFF_CTRL, 32'hC1);
		ext <= 6'h21;
		wait_load(VB + 20'd32, 8);
		wait_load(VB + 20'd116, 29);
		ext <= 6'h10;
		wait_load(VB + 20'd116, 29);
		ext <= 6'h00;
		wait_load(VB + 20'd36, 9);
		key_n <= 4'hB;
		@(posedge i_clk_sys);
		key_n <= 4'hF;
		wait_load(VB + 20'd52, 13);
		wr(ISVU_OFF_CTRL, 32'h0);
		// Watchdog restart by software is not modelled; one event each
		for (int i = 0; i < 5; i++) hit(0, 0, CE[i], CA[i], -1);
		nmi_n <= 1'b0;
		wait_load(20'hFFFF8, -1);
		nmi_n <= 1'b1;
		fire(0, 0, 34'h200000000);
		no_load(20);
		wr(ISVU_OFF_CTRL, 32'h2);
		hit(0, 0, 34'h200000000, 20'hFFFEC, -1);
		wr(ISVU_OFF_MATCH, 32'h401);
		wr(ISVU_OFF_CTRL, 32'h4);
		fire(0, 0, 34'h100400000);
		no_load(20);
		wr(ISVU_OFF_MATCH, 32'h400);
		hit(0, 0, 34'h100400000, 20'hFFFE8, -1);
		breakpoint_instr <= 1'b1;
		hit(0, 0, 34'h200, VB, -1);
		breakpoint_instr <= 1'b0;
		hit(0, 0, 34'h40, VB, 0);
		hit(0, 0, 34'h60, VB + 20'd128, 32);
		hit(0, 0, 34'h7F, VB + 20'd252, 63);
		wr(ISVU_OFF_CTRL, 32'h1);
		acc <= 1'b0;
		fire(32'h1 << 21, 0, 0);
		rst_n <= 1'b0;
		repeat (6) @(posedge i_clk_sys);
		rdc("ctrl", ISVU_OFF_CTRL, 32'h0);
		rdc("req", ISVU_OFF_REQ, 32'h0);
		rst_n <= 1'b1;
		acc <= 1'b1;
		wait_load(20'hFFFFC, -1);
		give_verdict();
	end
endmodule // interrupt_source_vector_unit_tb

// ==== isvu_asserts.sv ====
`timescale 1ns/1ps
// ----
// Port checker of the vector unit
// ----
module isvu_asserts (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [31:0] o_prdata,
	input wire logic i_accept_ok,
	input wire logic i_mem_valid,
	input wire logic o_mem_rd,
	input wire logic [19:0] o_mem_addr,
	input wire logic o_pc_load,
	input wire logic o_reset_hold
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	// Byte of an entry that is not its last
	sequence s_mid;
		i_mem_valid && o_mem_addr[1:0] != 2'h3;
	endsequence
	// Last byte of an entry with no redirect check behind it
	sequence s_last;
		i_mem_valid && o_mem_addr[1:0] == 2'h3 && o_mem_addr != 20'hFFFE7;
	endsequence
	property p_apb_ans;
		i_psel && i_penable && !o_pready |=> o_pready;
	endproperty
	a_apb_ans: assert property (p_apb_ans) else $error("pready late");
	property p_err_rdy;
		o_pslverr |-> o_pready;
	endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("stray pslverr");
	property p_wr_zero;
		o_pready && i_pwrite |-> o_prdata == 32'h0;
	endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("write rdata");
	property p_rst_idle;
		o_reset_hold [*2] |=> !o_mem_rd && !o_pc_load;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("busy in reset");
	property p_rst_vec;
		$fell(o_reset_hold) && i_accept_ok |-> ##[0:3] o_mem_addr == 20'hFFFFC;
	endproperty
	a_rst_vec: assert property (p_rst_vec) else $error("no reset vector");
	property p_next_byte;
		s_mid |-> ##2 o_mem_rd && o_mem_addr == $past(o_mem_addr) + 20'h1;
	endproperty
	a_next_byte: assert property (p_next_byte) else $error("byte order");
	property p_load;
		s_last |-> ##2 o_pc_load;
	endproperty
	a_load: assert property (p_load) else $error("pc not loaded");
	property p_rd_pulse;
		o_mem_rd |=> !o_mem_rd;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("long read");
endmodule // isvu_asserts

bind isvu_top isvu_asserts u_isvu_asserts (.i_clk_sys(i_clk_sys),
	.i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_prdata(o_prdata), .i_accept_ok(i_accept_ok),
	.i_mem_valid(i_mem_valid), .o_mem_rd(o_mem_rd),
	.o_mem_addr(o_mem_addr), .o_pc_load(o_pc_load),
	.o_reset_hold(o_reset_hold));

// ==== isvu_mem_model.sv ====
`timescale 1ns/1ps
// ----
// Vector memory beside the unit
// ----
module isvu_mem_model (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_mem_rd,
	input wire logic [19:0] i_mem_addr,
	input wire logic i_slow,
	input wire logic i_brk_ff,
	output logic o_mem_valid,
	output logic [7:0] o_mem_data
);
	logic busy; // A read is outstanding
	logic [1:0] cnt; // Wait cycles left
	logic [19:0] a; // Address being answered
	// One byte per read, promptly or after three idle cycles
	always @(posedge i_clk_sys) begin
		o_mem_valid <= 1'b0;
		// Undriven bus: inverts every idle cycle, so the last byte recurs every other cycle
		o_mem_data <= ~o_mem_data;
		if (i_sys_rst) begin
			busy <= 1'b0;
			o_mem_data <= 8'h00;
		end else if (i_mem_rd) begin
			busy <= 1'b1;
			a <= i_mem_addr;
			cnt <= i_slow ? 2'h3 : 2'h0;
		end else if (busy && cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end else if (busy) begin
			busy <= 1'b0;
			o_mem_valid <= 1'b1;
			o_mem_data <= (i_brk_ff && a == 20'hFFFE4) ? 8'hFF : a[7:0] ^ 8'h3C;
		end
	end
endmodule // isvu_mem_model

// ==== isvu_pkg.sv ====
// -----------------------------------------------------------------
// Shared constants and types of the interrupt source vector unit
// -----------------------------------------------------------------
package isvu_pkg;
	// Register offsets (byte addresses on APB)
	localparam logic [7:0] ISVU_OFF_CTRL = 8'h00;
	localparam logic [7:0] ISVU_OFF_FLOOR = 8'h04;
	localparam logic [7:0] ISVU_OFF_VBASE = 8'h08;
	localparam logic [7:0] ISVU_OFF_MATCH = 8'h0C;
	localparam logic [7:0] ISVU_OFF_EDGE = 8'h10;
	localparam logic [7:0] ISVU_OFF_REQ = 8'h14;
	localparam logic [7:0] ISVU_OFF_LVL0 = 8'h18;
	localparam logic [7:0] ISVU_OFF_STAT = 8'h28;
	// Control register field positions
	localparam int ISVU_CTRL_GIE = 0;
	localparam int ISVU_CTRL_SSTEP = 1;
	localparam int ISVU_CTRL_AMATCH = 2;
	localparam int ISVU_CTRL_I2C = 3;
	localparam int ISVU_CTRL_CAUSE8 = 6;
	localparam int ISVU_CTRL_CAUSE9 = 7;
	// Vector tables
	localparam logic [19:0] ISVU_FIX_BASE = 20'hFFFDC;
	localparam logic [7:0] ISVU_BRK_REDIRECT = 8'hFF;
	// Software numbers with a special source mux
	localparam int ISVU_NUM_EXT3 = 4;
	localparam int ISVU_NUM_SIO4 = 8;
	localparam int ISVU_NUM_SIO3 = 9;
	localparam int ISVU_NUM_KEY = 13;
	localparam int ISVU_NUM_U2TX = 15;
	localparam int ISVU_NUM_U2RX = 16;
	localparam int ISVU_NUM_EXT0 = 29;
	// Numbers fed straight from peripheral event inputs
	localparam logic [31:0] ISVU_DIRECT_MASK = 32'h1FFE5CE0;
	// Fixed vector kinds, in table order; VAR means variable table
	typedef enum logic [3:0] {
		K_UND = 4'h0, K_OVF = 4'h1, K_BRK = 4'h2, K_AMATCH = 4'h3,
		K_SSTEP = 4'h4, K_WDT = 4'h5, K_DBC = 4'h6, K_NMI = 4'h7,
		K_RESET = 4'h8, K_VAR = 4'h9
	} isvu_kind_t;
	// Acceptance order among non-maskable sources, first wins
	localparam isvu_kind_t ISVU_PRIO [9] = '{K_RESET, K_NMI, K_DBC,
		K_WDT, K_SSTEP, K_AMATCH, K_UND, K_OVF, K_BRK};
	// Vector fetch state machine, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001, ST_FETCH = 3'b010, ST_LOAD = 3'b100
	} isvu_state_t;
	// CPU side event strobes travelling together
	typedef struct packed {
		logic instr_done; // Instruction completed
		logic instr_start; // About to execute an instruction
		logic [19:0] instr_addr; // Address of that instruction
		logic trap_und; // Illegal opcode executed
		logic trap_ovf; // Overflow trap taken
		logic trap_brk; // Breakpoint instruction executed
		logic wdt_event; // Watchdog underflow
		logic dbg_break; // Debugger break request
		logic soft_req; // Software INT request
		logic [5:0] soft_num; // Its software number
	} isvu_cpu_evt_t;
	// Serial sources that share vector slots
	typedef struct packed {
		logic sio4; // Sync serial four event
		logic sio3; // Sync serial three event
		logic u2_tx; // Async serial two transmit
		logic u2_rx; // Async serial two receive
		logic u2_nack; // I2C acknowledge missing
		logic u2_ack; // I2C acknowledge seen
	} isvu_ser_evt_t;
	// All state of the unit
	typedef struct packed {
		isvu_state_t st;
		logic wait_rd;
		logic [1:0] bcnt;
		logic [19:0] faddr;
		logic [31:0] fdata;
		logic brk_chk;
		isvu_kind_t kind;
		logic [5:0] num;
		logic gie, sstep_en, amatch_en, i2c_mode;
		logic [1:0] cause_sel;
		logic [2:0] floor;
		logic [19:0] vbase, match_addr;
		logic [11:0] edge_pol;
		logic [31:0] req;
		logic [31:0][2:0] lvl;
		logic [8:0] spec;
		logic soft_pend;
		logic [5:0] soft_num;
		logic [7:0] s1, s2;
		logic [5:0] ext_prev;
		logic nmi_prev;
		logic [3:0] k1, k2;
		logic pready, pslverr;
		logic [31:0] prdata;
		logic mem_rd;
		logic [19:0] mem_addr;
		logic pc_load;
		logic [19:0] pc_value;
		logic [5:0] vec_num;
		logic rst_hold;
	} isvu_regs_t;
endpackage

// ==== isvu_top.sv ====
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
// What this block does
// - Low reset pin forces reset, own vector
// - Special sources ignore enable flag, levels
// - Step enable raises step after instructions
// - Match enable traps before matching instruction
// - No match unless first instruction byte
// - Peripherals maskable, share slots 4 to 31
// - Low key pin raises key interrupt
// - Edge pins trigger on selected edge
// - Accept loads PC from vector entry
// - Fixed table from FFFDC, four bytes each
// - Fixed vectors ordered undefined up to reset
// - Breakpoint vector FF redirects to slot zero
// - Variable table: 256 bytes at base
// - Entry n sits at base plus 4n
// - Numbers 4 to 12 assigned as listed
// - Numbers 13 to 18 assigned as listed
// - Numbers 19 to 31 assigned as listed
// - Numbers 0, 32 to 63 unmaskable software
// - Cause select bits pick slot 8, 9 source
// - I2C mode routes acknowledge events to serial two
// - Maskable accept needs flag, request, higher level
// - Request set by hardware, cleared on fetch
// - Enable flag gates maskables, cleared at reset
module isvu_top (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [31:0] o_prdata,
	// Pins, asynchronous
	input wire logic i_reset_pin_n,
	input wire logic i_nmi_pin_n,
	input wire logic [5:0] i_ext_pin,
	input wire logic [3:0] i_key_pin_n,
	// Same clock sources
	input wire logic [31:0] i_periph_evt,
	input wire isvu_pkg::isvu_ser_evt_t i_ser_evt,
	input wire isvu_pkg::isvu_cpu_evt_t i_cpu_evt,
	input wire logic i_accept_ok,
	// Vector byte reads
	input wire logic i_mem_valid,
	input wire logic [7:0] i_mem_data,
	output logic o_mem_rd,
	output logic [19:0] o_mem_addr,
	// Program counter load
	output logic o_pc_load,
	output logic [19:0] o_pc_value,
	output logic [5:0] o_vec_num,
	output logic o_reset_hold
);
	import isvu_pkg::*;

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	// Register index for an APB byte address, 15 when unmapped
	function automatic logic [3:0] reg_sel(input logic [7:0] a);
		logic [3:0] s;
		s = 4'hF;
		if (a[1:0] == 2'b00 && a <= ISVU_OFF_STAT) begin
			s = a[5:2];
		end
		return s;
	endfunction

	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	isvu_regs_t r_reg; // Registered state
	isvu_regs_t r_next; // Next state
	logic [31:0] ev; // Raw request events this cycle
	logic [31:0] clr; // Software clears of request bits
	logic [31:0] acc_clr; // Hardware clear on vector load
	logic [5:0] hit; // Edge pin triggers
	logic found; // A non-maskable source was picked
	isvu_kind_t sel; // The picked kind
	logic [2:0] best_lvl; // Highest eligible maskable level
	logic [5:0] best_num; // Its software number
	logic hold; // Reset pin is low (synchronised)
	logic [3:0] rs; // Decoded register

	// -------------------------------------------------------------
	// Next state logic
	// -------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.mem_rd = 1'b0;
		r_next.pc_load = 1'b0;
		r_next.pready = 1'b0;
		// Error and read data stand only beside the ready pulse
		r_next.pslverr = 1'b0;
		r_next.prdata = '0;
		clr = '0;
		acc_clr = '0;
		found = 1'b0;
		sel = K_RESET;
		best_lvl = '0;
		best_num = '0;
		rs = reg_sel(i_paddr);

		// Two-stage synchronisers; only stage two is looked at
		r_next.s1 = {i_ext_pin, i_nmi_pin_n, i_reset_pin_n};
		r_next.s2 = r_reg.s1;
		r_next.k1 = i_key_pin_n;
		r_next.k2 = r_reg.k1;
		r_next.ext_prev = r_reg.s2[7:2];
		r_next.nmi_prev = r_reg.s2[1];
		hold = ~r_reg.s2[0];

		// Edge pins: polarity pair per pin, b0 rising, b1 falling
		for (int i = 0; i < 6; i++) begin
			hit[i] = (r_reg.edge_pol[2*i] & r_reg.s2[i+2]
				& ~r_reg.ext_prev[i])
				| (r_reg.edge_pol[2*i+1] & ~r_reg.s2[i+2]
				& r_reg.ext_prev[i]);
		end

		// Map sources onto software numbers
		ev = i_periph_evt & ISVU_DIRECT_MASK;
		ev[ISVU_NUM_EXT3] = hit[3];
		ev[ISVU_NUM_SIO4] = r_reg.cause_sel[0] ? hit[5]
			: i_ser_evt.sio4;
		ev[ISVU_NUM_SIO3] = r_reg.cause_sel[1] ? hit[4]
			: i_ser_evt.sio3;
		ev[ISVU_NUM_KEY] = |(~r_reg.k2);
		ev[ISVU_NUM_U2TX] = r_reg.i2c_mode ? i_ser_evt.u2_nack
			: i_ser_evt.u2_tx;
		ev[ISVU_NUM_U2RX] = r_reg.i2c_mode ? i_ser_evt.u2_ack
			: i_ser_evt.u2_rx;
		ev[ISVU_NUM_EXT0 +: 3] = hit[2:0];

		// APB slave: answer in the second access cycle
		if (i_psel && i_penable && !r_reg.pready) begin
			r_next.pready = 1'b1;
			r_next.pslverr = (rs == 4'hF);
			r_next.prdata = '0;
			if (i_pwrite) begin
				case (rs)
					ISVU_OFF_CTRL[5:2]: begin
						r_next.gie = i_pwdata[ISVU_CTRL_GIE];
						r_next.sstep_en = i_pwdata[ISVU_CTRL_SSTEP];
						r_next.amatch_en = i_pwdata[ISVU_CTRL_AMATCH];
						r_next.i2c_mode = i_pwdata[ISVU_CTRL_I2C];
						r_next.cause_sel = {i_pwdata[ISVU_CTRL_CAUSE9],
							i_pwdata[ISVU_CTRL_CAUSE8]};
					end
					ISVU_OFF_FLOOR[5:2]: r_next.floor = i_pwdata[2:0];
					ISVU_OFF_VBASE[5:2]: r_next.vbase = i_pwdata[19:0];
					ISVU_OFF_MATCH[5:2]: r_next.match_addr = i_pwdata[19:0];
					ISVU_OFF_EDGE[5:2]: r_next.edge_pol = i_pwdata[11:0];
					// Write one to drop a request; cannot set one
					ISVU_OFF_REQ[5:2]: clr = i_pwdata;
					ISVU_OFF_STAT[5:2]: begin
						// Read only
					end
					default: begin
						// Level words: eight nibbles each
						if (rs >= ISVU_OFF_LVL0[5:2] && rs != 4'hF) begin
							for (int j = 0; j < 8; j++) begin
								r_next.lvl[{rs[1:0] - ISVU_OFF_LVL0[3:2],
									3'(j)}] = i_pwdata[4*j +: 3];
							end
						end
					end
				endcase
			end else begin
				case (rs)
					ISVU_OFF_CTRL[5:2]: r_next.prdata = {24'h000000,
						r_reg.cause_sel, 2'b00, r_reg.i2c_mode,
						r_reg.amatch_en, r_reg.sstep_en, r_reg.gie};
					ISVU_OFF_FLOOR[5:2]: r_next.prdata = {29'h0, r_reg.floor};
					ISVU_OFF_VBASE[5:2]: r_next.prdata = {12'h000, r_reg.vbase};
					ISVU_OFF_MATCH[5:2]: r_next.prdata = {12'h000,
						r_reg.match_addr};
					ISVU_OFF_EDGE[5:2]: r_next.prdata = {20'h00000,
						r_reg.edge_pol};
					ISVU_OFF_REQ[5:2]: r_next.prdata = r_reg.req;
					ISVU_OFF_STAT[5:2]: r_next.prdata = {16'h0000,
						r_reg.st != ST_IDLE, r_reg.rst_hold, 2'b00,
						r_reg.kind, 2'b00, r_reg.vec_num};
					default: begin
						if (rs >= ISVU_OFF_LVL0[5:2] && rs != 4'hF) begin
							for (int j = 0; j < 8; j++) begin
								r_next.prdata[4*j +: 3] = r_reg.lvl[
									{rs[1:0] - ISVU_OFF_LVL0[3:2], 3'(j)}];
							end
						end
					end
				endcase
			end
		end

		// Acceptance: one source per acceptance, rest stay pending
		case (r_reg.st)
			ST_IDLE: begin
				if (i_accept_ok && !hold) begin
					// Special sources bypass flag and levels
					for (int k = 0; k < 9; k++) begin
						if (!found && r_reg.spec[ISVU_PRIO[k]]) begin
							found = 1'b1;
							sel = ISVU_PRIO[k];
						end
					end
					// Highest level above the floor, low number on ties
					for (int i = 1; i < 32; i++) begin
						if (r_reg.req[i] && r_reg.lvl[i] > r_reg.floor
							&& r_reg.lvl[i] > best_lvl) begin
							best_lvl = r_reg.lvl[i];
							best_num = 6'(i);
						end
					end
					if (found) begin
						r_next.spec[sel] = 1'b0;
						r_next.kind = sel;
						r_next.num = '0;
						r_next.faddr = ISVU_FIX_BASE
							+ {14'h0000, sel, 2'b00};
						r_next.brk_chk = (sel == K_BRK);
						r_next.st = ST_FETCH;
					end else if (r_reg.soft_pend) begin
						// Software INT: never masked by the flag
						r_next.soft_pend = 1'b0;
						r_next.kind = K_VAR;
						r_next.num = r_reg.soft_num;
						r_next.faddr = r_reg.vbase
							+ {12'h000, r_reg.soft_num, 2'b00};
						r_next.brk_chk = 1'b0;
						r_next.st = ST_FETCH;
					end else if (r_reg.gie && best_lvl != 3'h0) begin
						r_next.kind = K_VAR;
						r_next.num = best_num;
						r_next.faddr = r_reg.vbase
							+ {12'h000, best_num, 2'b00};
						r_next.brk_chk = 1'b0;
						r_next.st = ST_FETCH;
					end
					r_next.bcnt = '0;
					r_next.wait_rd = 1'b0;
				end
			end
			ST_FETCH: begin
				if (!r_reg.wait_rd) begin
					// Issue one byte read of the entry
					r_next.mem_rd = 1'b1;
					r_next.mem_addr = r_reg.faddr + {18'h00000, r_reg.bcnt};
					r_next.wait_rd = 1'b1;
				end else if (i_mem_valid) begin
					r_next.wait_rd = 1'b0;
					// Lowest address is least significant
					r_next.fdata[8*r_reg.bcnt +: 8] = i_mem_data;
					r_next.bcnt = r_reg.bcnt + 2'd1;
					if (r_reg.bcnt == 2'd3) begin
						if (r_reg.brk_chk
							&& r_reg.fdata[7:0] == ISVU_BRK_REDIRECT) begin
							// Fall back to variable slot zero
							r_next.faddr = r_reg.vbase;
							r_next.brk_chk = 1'b0;
							r_next.kind = K_VAR;
						end else begin
							r_next.st = ST_LOAD;
						end
					end
				end
			end
			ST_LOAD: begin
				r_next.pc_load = 1'b1;
				r_next.pc_value = r_reg.fdata[19:0];
				r_next.vec_num = r_reg.num;
				// Any variable-table load below 32 drops that number's request
				if (r_reg.kind == K_VAR && r_reg.num < 6'd32) begin
					acc_clr[r_reg.num[4:0]] = 1'b1;
				end
				r_next.st = ST_IDLE;
			end
			default: r_next.st = ST_IDLE;
		endcase

		// Request bits: a new event wins over a software or load clear
		ev[0] = 1'b0;
		r_next.req = (r_reg.req & ~clr & ~acc_clr) | ev;

		// Special sources set after the clears above
		if (!r_reg.s2[1] && r_reg.nmi_prev) begin
			r_next.spec[K_NMI] = 1'b1;
		end
		if (i_cpu_evt.wdt_event) begin
			r_next.spec[K_WDT] = 1'b1;
		end
		if (i_cpu_evt.dbg_break) begin
			r_next.spec[K_DBC] = 1'b1;
		end
		if (r_reg.sstep_en && i_cpu_evt.instr_done) begin
			r_next.spec[K_SSTEP] = 1'b1;
		end
		// Start strobe only comes on an instruction's first byte
		if (r_reg.amatch_en && i_cpu_evt.instr_start
			&& i_cpu_evt.instr_addr == r_reg.match_addr) begin
			r_next.spec[K_AMATCH] = 1'b1;
		end
		if (i_cpu_evt.trap_und) begin
			r_next.spec[K_UND] = 1'b1;
		end
		if (i_cpu_evt.trap_ovf) begin
			r_next.spec[K_OVF] = 1'b1;
		end
		if (i_cpu_evt.trap_brk) begin
			r_next.spec[K_BRK] = 1'b1;
		end
		if (i_cpu_evt.soft_req) begin
			r_next.soft_pend = 1'b1;
			r_next.soft_num = i_cpu_evt.soft_num;
		end

		// Reset pin low: abort all, drop the flag, keep reset pending
		r_next.rst_hold = hold;
		if (hold) begin
			r_next.st = ST_IDLE;
			r_next.gie = 1'b0;
			r_next.spec = '0;
			r_next.spec[K_RESET] = 1'b1;
			r_next.soft_pend = 1'b0;
			r_next.req = '0;
		end
	end

	// -------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------
	// Synchronous reset; all fields but st (ST_IDLE) clear, which also reads the
	// reset pin as low so a reset vector fetch follows
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			r_reg <= '0;
			r_reg.st <= ST_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	// -------------------------------------------------------------
	// Outputs, straight from flops
	// -------------------------------------------------------------
	assign o_pready = r_reg.pready;
	assign o_pslverr = r_reg.pslverr;
	assign o_prdata = r_reg.prdata;
	assign o_mem_rd = r_reg.mem_rd;
	assign o_mem_addr = r_reg.mem_addr;
	assign o_pc_load = r_reg.pc_load;
	assign o_pc_value = r_reg.pc_value;
	assign o_vec_num = r_reg.vec_num;
	assign o_reset_hold = r_reg.rst_hold;
endmodule // isvu_top
